/* rtl/test_pattern_top.sv */
// Purpose: output test-pattern generator with latency budget reporting
// Assumes: one encode clock; samples and register port are on that clock
// Notes:   patterns and samples leave through an 8-word FIFO
//
// Contract
// - converter core latency is a constant 26 encode clocks.
// - processing latency 29 full, 35 requantizer, 33 VARIABLE_DYNAMIC_RANGE_MODE, 57 decimate+requant.
// - downconverter latency 78/132/232/432 for one to four half-band stages.
// - link latency 13, 28, 53 or 7 by full-bandwidth quick config.
// - decimating 4/8-converter configs fixed; four-lane dual at decimate_by_two is 30.
// - total latency is processing latency plus link latency.
// - any test mode replaces conversion results with the chosen pattern.
// - either PN reset bit resets the pseudorandom generators.
// - patterns ignore analog input but advance only on encode-clock samples.
// - in-phase carries channel A pattern, quadrature carries channel B.
// - fourth downconverter: I from channel A on bit 0, Q never patterned.
// - codes 0000 off, 0001 midscale, 0010 +full-scale, 0011 -full-scale.
// - code 0100 alternates checkerboard words 0x1555 and 0x2AAA.
// - code 0101 long PN x^23+x^18+1 from its seed.
// - code 0110 short PN x^9+x^5+1 from seed 0x092.
// - code 0111 alternates all-zeros and all-ones, zeros first.
// - code 1000 plays four user words bits 15:2, repeat or single.
// - code 1111 ramp incrementing by one, wrapping modulo 2^14.
`timescale 1ns/1ps
`default_nettype none

// ----
// sample FIFO
// ----
module sample_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;
  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    wr_d  = push ? wr_q + PW'(1) : wr_q;
    rd_d  = pop ? rd_q + PW'(1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (PW+1)'(1);
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  // storage carries no reset
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// ----
// top
// ----
module test_pattern_top
  import test_pattern_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic                reg_wr_en,
  input  wire logic [DATA_W-1:0]   reg_wr_data,
  output logic [DATA_W-1:0]        reg_rd_data,
  // configuration from the rest of the chip
  input  wire logic [2:0]          app_mode,
  input  wire logic [4:0]          dec_ratio,
  // converted samples
  input  wire logic                sample_valid,
  output logic                     sample_ready,
  input  wire logic [SAMPLE_W-1:0] sample_a,
  input  wire logic [SAMPLE_W-1:0] sample_b,
  // formatted output stream
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [SAMPLE_W-1:0]      out_a,
  output logic [SAMPLE_W-1:0]      out_b,
  // downconverter pattern routing
  output logic [3:0]               ddc_i_pattern_en,
  output logic [3:0]               ddc_q_pattern_en,
  // latency budget
  output logic [LAT_W-1:0]         core_latency,
  output logic [LAT_W-1:0]         proc_latency,
  output logic [LAT_W-1:0]         link_latency,
  output logic [LAT_W-1:0]         total_latency
);

  // ----
  // functions
  // ----
  function automatic logic [9:0] proc_lat(input logic [2:0] m);
    case (m)
      APP_FULL_BW:  proc_lat = LAT_FULL_BW;
      APP_REQUANT:  proc_lat = LAT_REQUANT;
      APP_VDR:      proc_lat = LAT_VDR;
      APP_DECIMATE_BY_TWO_REQ: proc_lat = LAT_DECIMATE_BY_TWO_REQ;
      APP_DDC_HB1:  proc_lat = LAT_DDC_HB1;
      APP_DDC_HB2:  proc_lat = LAT_DDC_HB2;
      APP_DDC_HB3:  proc_lat = LAT_DDC_HB3;
      default:      proc_lat = LAT_DDC_HB4;
    endcase
  endfunction

  function automatic logic [9:0] link_lat(input logic [7:0] qc,
                                          input logic [4:0] dr);
    case (qc)
      QC_01, QC_49:        link_lat = LINK_LAT_13;
      QC_40, QC_41:        link_lat = LINK_LAT_28;
      QC_80, QC_81:        link_lat = LINK_LAT_53;
      QC_0A:               link_lat = LINK_LAT_7;
      QC_88, QC_89: begin
        link_lat = (dr == DEC_RATIO_2) ? LINK_LAT_30 : LINK_LAT_28;
      end
      QC_13, QC_5B:        link_lat = LINK_LAT_4;
      QC_52, QC_9A:        link_lat = LINK_LAT_7;
      QC_91:               link_lat = LINK_LAT_13;
      QC_1C:               link_lat = LINK_LAT_2;
      default:             link_lat = LINK_LAT_NONE;
    endcase
  endfunction

  // bit 0 leaves first as the word's MSB; returns {next state, word}
  function automatic logic [36:0] pn_run(input logic [22:0] s, int w, t);
    logic [13:0] o;
    for (int j = 0; j < 14; j++) begin
      o[13-j] = s[0];
      s = (s >> 1) | (23'(s[0] ^ s[w-t]) << (w - 1));
    end
    return {s, o};
  endfunction

  // ----
  // registers
  // ----
  logic [7:0] ddc_ctrl_q [4];
  logic [7:0] ddc_ctrl_d [4];
  logic [7:0] test_ctrl_q, test_ctrl_d;
  logic [7:0] user_q [8];
  logic [7:0] user_d [8];
  logic [7:0] quick_cfg_q, quick_cfg_d;
  logic [7:0] rd_q, rd_d;
  logic [3:0] user_idx;

  assign user_idx = 4'(reg_addr - ADDR_USER_FIRST);

  always_comb begin
    ddc_ctrl_d  = ddc_ctrl_q;
    test_ctrl_d = test_ctrl_q;
    user_d      = user_q;
    quick_cfg_d = quick_cfg_q;
    rd_d        = 8'h00;
    case (reg_addr)
      ADDR_DDC0_CTRL: rd_d = ddc_ctrl_q[0];
      ADDR_DDC1_CTRL: rd_d = ddc_ctrl_q[1];
      ADDR_DDC2_CTRL: rd_d = ddc_ctrl_q[2];
      ADDR_FOURTH_DOWNCONVERTER_CTRL: rd_d = ddc_ctrl_q[3];
      ADDR_TEST_CTRL: rd_d = test_ctrl_q;
      ADDR_QUICK_CFG: rd_d = quick_cfg_q;
      default: begin
        if (reg_addr >= ADDR_USER_FIRST && reg_addr <= ADDR_USER_LAST) begin
          rd_d = user_q[user_idx[2:0]];
        end
      end
    endcase
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_DDC0_CTRL: ddc_ctrl_d[0] = reg_wr_data;
        ADDR_DDC1_CTRL: ddc_ctrl_d[1] = reg_wr_data;
        ADDR_DDC2_CTRL: ddc_ctrl_d[2] = reg_wr_data;
        ADDR_FOURTH_DOWNCONVERTER_CTRL: ddc_ctrl_d[3] = reg_wr_data;
        ADDR_TEST_CTRL: test_ctrl_d   = reg_wr_data;
        ADDR_QUICK_CFG: quick_cfg_d   = reg_wr_data;
        default: begin
          if (reg_addr >= ADDR_USER_FIRST &&
              reg_addr <= ADDR_USER_LAST) begin
            user_d[user_idx[2:0]] = reg_wr_data;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        ddc_ctrl_q[i] <= REG_RESET;
      end
      for (int i = 0; i < 8; i++) begin
        user_q[i] <= REG_RESET;
      end
      test_ctrl_q <= REG_RESET;
      quick_cfg_q <= REG_RESET;
      rd_q        <= REG_RESET;
    end else begin
      ddc_ctrl_q  <= ddc_ctrl_d;
      user_q      <= user_d;
      test_ctrl_q <= test_ctrl_d;
      quick_cfg_q <= quick_cfg_d;
      rd_q        <= rd_d;
    end
  end

  assign reg_rd_data = rd_q;

  // ----
  // pattern generators
  // ----
  logic [3:0]  mode;
  logic        step;
  logic        fifo_in_ready;
  logic        phase_q, phase_d;
  logic [13:0] ramp_q, ramp_d;
  logic [1:0]  user_pos_q, user_pos_d;
  logic        user_done_q, user_done_d;
  logic [22:0] pn_long_q, pn_long_d;
  logic [8:0]  pn_short_q, pn_short_d;
  logic [36:0] pn_long_nx, pn_short_nx;
  logic        pn_rst;
  logic [13:0] pattern;
  logic [15:0] user_word;
  assign mode   = test_ctrl_q[TM_MODE_LSB +: 4];
  assign pn_long_nx  = pn_run(pn_long_q, 23, PN_LONG_TAP);
  assign pn_short_nx = pn_run(23'(pn_short_q), 9, PN_SHORT_TAP);
  assign pn_rst = test_ctrl_q[TM_PN_LONG_RST] || test_ctrl_q[TM_PN_SHORT_RST];
  // advance only on encode-clock samples accepted downstream
  assign step   = sample_valid && fifo_in_ready;
  assign sample_ready = fifo_in_ready;
  assign user_word = {user_q[{user_pos_q, 1'b1}], user_q[{user_pos_q, 1'b0}]};

  always_comb begin
    phase_d     = phase_q;
    ramp_d      = ramp_q;
    user_pos_d  = user_pos_q;
    user_done_d = user_done_q;
    pn_long_d   = pn_long_q;
    pn_short_d  = pn_short_q;
    if (mode == TM_OFF) begin
      phase_d     = 1'b0;
      ramp_d      = '0;
      user_pos_d  = '0;
      user_done_d = 1'b0;
    end else if (step) begin
      phase_d = !phase_q;
      ramp_d  = ramp_q + 14'h0001;
      if (user_pos_q == 2'h3) begin
        user_done_d = test_ctrl_q[TM_USER_SINGLE] || user_done_q;
      end
      user_pos_d = user_pos_q + 2'h1;
      pn_long_d  = pn_long_nx[36:14];
      pn_short_d = pn_short_nx[22:14];
    end
    if (pn_rst) begin
      pn_long_d  = SEED_PN_LONG;
      pn_short_d = SEED_PN_SHORT;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_q     <= 1'b0;
      ramp_q      <= '0;
      user_pos_q  <= '0;
      user_done_q <= 1'b0;
      pn_long_q   <= SEED_PN_LONG;
      pn_short_q  <= SEED_PN_SHORT;
    end else begin
      phase_q     <= phase_d;
      ramp_q      <= ramp_d;
      user_pos_q  <= user_pos_d;
      user_done_q <= user_done_d;
      pn_long_q   <= pn_long_d;
      pn_short_q  <= pn_short_d;
    end
  end

  always_comb begin
    case (mode)
      TM_MIDSCALE: pattern = LVL_MID;
      TM_POS_FS:   pattern = LVL_POS_FS;
      TM_NEG_FS:   pattern = LVL_NEG_FS;
      TM_CHECKER:  pattern = phase_q ? LVL_CHECK_B : LVL_CHECK_A;
      TM_PN_LONG:  pattern = pn_long_nx[13:0];
      TM_PN_SHORT: pattern = pn_short_nx[13:0];
      TM_TOGGLE:   pattern = phase_q ? LVL_ONES : LVL_ZEROS;
      // user words, zeros after the fourth in single mode
      TM_USER:     pattern = user_done_q ? LVL_ZEROS : user_word[15:2];
      TM_RAMP:     pattern = ramp_q;
      default:     pattern = LVL_MID;
    endcase
  end

  // ----
  // output path
  // ----
  logic [27:0] fifo_in, fifo_out;
  // pattern replaces conversion results; A to I, B to Q
  assign fifo_in = (mode == TM_OFF) ? {sample_a, sample_b} : {pattern, pattern};

  sample_fifo #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (sample_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_a = fifo_out[27:14];
  assign out_b = fifo_out[13:0];

  // per-downconverter enables; fourth has no Q pattern
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ddc_i_pattern_en[i] = ddc_ctrl_q[i][DDC_I_EN];
      ddc_q_pattern_en[i] = ddc_ctrl_q[i][DDC_Q_EN];
    end
    ddc_i_pattern_en[3] = ddc_ctrl_q[3][DDC_I_EN];
    ddc_q_pattern_en[3] = 1'b0;
  end

  // ----
  // latency budget
  // ----
  logic [9:0] proc_lat_q, proc_lat_d, link_lat_q, link_lat_d;
  always_comb begin
    proc_lat_d = proc_lat(app_mode);
    link_lat_d = link_lat(quick_cfg_q, dec_ratio);
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      proc_lat_q <= LAT_FULL_BW;
      link_lat_q <= LINK_LAT_NONE;
    end else begin
      proc_lat_q <= proc_lat_d;
      link_lat_q <= link_lat_d;
    end
  end

  assign core_latency  = LAT_CORE;
  assign proc_latency  = proc_lat_q;
  assign link_latency  = link_lat_q;
  assign total_latency = LAT_W'(proc_lat_q + link_lat_q);

endmodule

`default_nettype wire

/* rtl/test_pattern_pkg.sv */
// Purpose: shared constants for the converter test-pattern and latency block
// Assumes: 14-bit samples, 12-bit register addresses, 8-bit register data
// Notes:   all offsets, fields, seeds and latency figures live here
package test_pattern_pkg;

  // ----
  // widths
  // ----
  localparam int SAMPLE_W  = 14;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int LAT_W     = 10;
  localparam int FIFO_DEPTH = 8;

  // ----
  // register offsets
  // ----
  localparam logic [11:0] ADDR_DDC0_CTRL   = 12'h327;
  localparam logic [11:0] ADDR_DDC1_CTRL   = 12'h347;
  localparam logic [11:0] ADDR_DDC2_CTRL   = 12'h367;
  localparam logic [11:0] ADDR_FOURTH_DOWNCONVERTER_CTRL   = 12'h387;
  localparam logic [11:0] ADDR_TEST_CTRL   = 12'h550;
  localparam logic [11:0] ADDR_USER_FIRST  = 12'h551;
  localparam logic [11:0] ADDR_USER_LAST   = 12'h558;
  localparam logic [11:0] ADDR_QUICK_CFG   = 12'h570;
  localparam logic [7:0]  REG_RESET        = 8'h00;

  // ----
  // field positions
  // ----
  localparam int TM_MODE_LSB   = 0;
  localparam int TM_PN_LONG_RST  = 4;
  localparam int TM_PN_SHORT_RST = 5;
  localparam int TM_USER_SINGLE  = 7;
  localparam int DDC_I_EN      = 0;
  localparam int DDC_Q_EN      = 2;

  // ----
  // test mode codes
  // ----
  localparam logic [3:0] TM_OFF      = 4'h0;
  localparam logic [3:0] TM_MIDSCALE = 4'h1;
  localparam logic [3:0] TM_POS_FS   = 4'h2;
  localparam logic [3:0] TM_NEG_FS   = 4'h3;
  localparam logic [3:0] TM_CHECKER  = 4'h4;
  localparam logic [3:0] TM_PN_LONG  = 4'h5;
  localparam logic [3:0] TM_PN_SHORT = 4'h6;
  localparam logic [3:0] TM_TOGGLE   = 4'h7;
  localparam logic [3:0] TM_USER     = 4'h8;
  localparam logic [3:0] TM_RAMP     = 4'hF;

  // ----
  // pattern levels and seeds
  // ----
  localparam logic [13:0] LVL_MID     = 14'h0000;
  localparam logic [13:0] LVL_POS_FS  = 14'h1FFF;
  localparam logic [13:0] LVL_NEG_FS  = 14'h2000;
  localparam logic [13:0] LVL_CHECK_A = 14'h1555;
  localparam logic [13:0] LVL_CHECK_B = 14'h2AAA;
  localparam logic [13:0] LVL_ZEROS   = 14'h0000;
  localparam logic [13:0] LVL_ONES    = 14'h3FFF;
  localparam logic [22:0] SEED_PN_LONG  = 23'h003AFF;
  localparam logic [8:0]  SEED_PN_SHORT = 9'h092;
  localparam int PN_LONG_TAP  = 18;
  localparam int PN_SHORT_TAP = 5;

  // ----
  // application modes (processing path)
  // ----
  localparam logic [2:0] APP_FULL_BW   = 3'h0;
  localparam logic [2:0] APP_REQUANT   = 3'h1;
  localparam logic [2:0] APP_VDR       = 3'h2;
  localparam logic [2:0] APP_DECIMATE_BY_TWO_REQ  = 3'h3;
  localparam logic [2:0] APP_DDC_HB1   = 3'h4;
  localparam logic [2:0] APP_DDC_HB2   = 3'h5;
  localparam logic [2:0] APP_DDC_HB3   = 3'h6;
  localparam logic [2:0] APP_DDC_HB4   = 3'h7;

  // ----
  // latency figures in encode clocks
  // ----
  localparam logic [9:0] LAT_CORE      = 10'd26;
  localparam logic [9:0] LAT_FULL_BW   = 10'd29;
  localparam logic [9:0] LAT_REQUANT   = 10'd35;
  localparam logic [9:0] LAT_VDR       = 10'd33;
  localparam logic [9:0] LAT_DECIMATE_BY_TWO_REQ  = 10'd57;
  localparam logic [9:0] LAT_DDC_HB1   = 10'd78;
  localparam logic [9:0] LAT_DDC_HB2   = 10'd132;
  localparam logic [9:0] LAT_DDC_HB3   = 10'd232;
  localparam logic [9:0] LAT_DDC_HB4   = 10'd432;

  // quick configuration codes and link-block latency
  localparam logic [7:0] QC_01 = 8'h01;
  localparam logic [7:0] QC_40 = 8'h40;
  localparam logic [7:0] QC_41 = 8'h41;
  localparam logic [7:0] QC_80 = 8'h80;
  localparam logic [7:0] QC_81 = 8'h81;
  localparam logic [7:0] QC_0A = 8'h0A;
  localparam logic [7:0] QC_49 = 8'h49;
  localparam logic [7:0] QC_88 = 8'h88;
  localparam logic [7:0] QC_89 = 8'h89;
  localparam logic [7:0] QC_13 = 8'h13;
  localparam logic [7:0] QC_52 = 8'h52;
  localparam logic [7:0] QC_91 = 8'h91;
  localparam logic [7:0] QC_1C = 8'h1C;
  localparam logic [7:0] QC_5B = 8'h5B;
  localparam logic [7:0] QC_9A = 8'h9A;
  localparam logic [9:0] LINK_LAT_2  = 10'd2;
  localparam logic [9:0] LINK_LAT_4  = 10'd4;
  localparam logic [9:0] LINK_LAT_7  = 10'd7;
  localparam logic [9:0] LINK_LAT_13 = 10'd13;
  localparam logic [9:0] LINK_LAT_28 = 10'd28;
  localparam logic [9:0] LINK_LAT_30 = 10'd30;
  localparam logic [9:0] LINK_LAT_53 = 10'd53;
  localparam logic [9:0] LINK_LAT_NONE = 10'd0;
  localparam logic [4:0] DEC_RATIO_1 = 5'd1;
  localparam logic [4:0] DEC_RATIO_2 = 5'd2;

endpackage

/* verif/test_pattern_checker.sv */
// Purpose: port assertions for the test-pattern and latency block
// Assumes: one encode clock, asynchronous active-high reset
// Notes:   quick config is tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module test_pattern_checker
  import test_pattern_pkg::*;
(
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                reset,
  // register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic                reg_wr_en,
  input wire logic [DATA_W-1:0]   reg_wr_data,
  input wire logic [DATA_W-1:0]   reg_rd_data,
  // configuration and stream
  input wire logic [2:0]          app_mode,
  input wire logic [4:0]          dec_ratio,
  input wire logic                sample_valid,
  input wire logic                sample_ready,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic [SAMPLE_W-1:0] out_a,
  input wire logic [3:0]          ddc_q_pattern_en,
  // latency budget
  input wire logic [LAT_W-1:0]    core_latency,
  input wire logic [LAT_W-1:0]    proc_latency,
  input wire logic [LAT_W-1:0]    link_latency,
  input wire logic [LAT_W-1:0]    total_latency
);
  localparam logic [9:0] PROC_T [8] = '{10'h01D, 10'h023, 10'h021,
    10'h039, 10'h04E, 10'h084, 10'h0E8, 10'h1B0};
  logic [7:0] qc_q;
  logic [7:0] qc_d;

  // ----
  // quick config shadow
  // ----
  always_comb begin
    qc_d = qc_q;
    if (reg_wr_en && reg_addr == ADDR_QUICK_CFG)
      qc_d = reg_wr_data;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      qc_q <= 8'h00;
    else
      qc_q <= qc_d;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_CORE_FIXED: assert property (core_latency == 10'h01A)
    else $error("core latency wrong");
  AST_PROC_TABLE: assert property (!$past(reset) |->
    proc_latency == PROC_T[$past(app_mode)])
    else $error("processing latency wrong");
  AST_LINK_FULL: assert property ($past(qc_q) == 8'h0A &&
    $past(dec_ratio) == 5'h01 |-> link_latency == 10'h007)
    else $error("full bandwidth link latency wrong");
  AST_LINK_DEC: assert property ($past(qc_q) == 8'h88 &&
    $past(dec_ratio) == 5'h02 |-> link_latency == 10'h01E)
    else $error("decimating link latency wrong");
  AST_TOTAL_SUM: assert property (
    total_latency == proc_latency + link_latency)
    else $error("total latency not the sum");
  AST_PUSH_SHOWS: assert property (sample_valid && sample_ready
    && !out_valid |=> out_valid)
    else $error("pushed word not presented");
  AST_HEAD_HOLDS: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_a))
    else $error("head word lost during stall");
  AST_Q3_NONE: assert property (ddc_q_pattern_en[3] == 1'b0)
    else $error("fourth quadrature patterned");
  AST_MODE_READ: assert property (reg_wr_en &&
    reg_addr == ADDR_TEST_CTRL ##1 reg_addr == ADDR_TEST_CTRL && !reg_wr_en
    |=> reg_rd_data == $past(reg_wr_data, 2))
    else $error("test control readback wrong");

  COV_FULL: cover property (sample_valid && !sample_ready);
  COV_STALL: cover property (out_valid && !out_ready);
  COV_DEC16: cover property (qc_q == 8'h91 && dec_ratio == 5'h10);
endmodule

bind test_pattern_top test_pattern_checker chk_u (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .app_mode(app_mode), .dec_ratio(dec_ratio),
  .sample_valid(sample_valid), .sample_ready(sample_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_a(out_a),
  .ddc_q_pattern_en(ddc_q_pattern_en), .core_latency(core_latency),
  .proc_latency(proc_latency), .link_latency(link_latency),
  .total_latency(total_latency));
`default_nettype wire

/* verif/stream_sink.sv */
// Purpose: far-side stream consumer that records drained words
// Assumes: accepts every cycle unless stalled
// Notes:   stall lets the bench back-pressure the FIFO
`timescale 1ns/1ps
`default_nettype none
module stream_sink (
  // clock and stream
  input  wire logic        ref_clk,
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [13:0] out_a,
  input  wire logic [13:0] out_b,
  // control
  input  wire logic        stall
);
  logic [13:0] got_a[$];
  logic [13:0] got_b[$];
  assign out_ready = !stall;
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got_a.push_back(out_a);
      got_b.push_back(out_b);
    end
  end
endmodule
`default_nettype wire

/* verif/adc_test_pattern_latency_bench.sv */
// Purpose: self-checking bench for the test-pattern and latency block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expected words are worked out here from the pattern table
`timescale 1ns/1ps
`default_nettype none
module adc_test_pattern_latency_bench
  import test_pattern_pkg::*;
;
  localparam logic [9:0] PROC_T [8] = '{10'h01D, 10'h023, 10'h021,
    10'h039, 10'h04E, 10'h084, 10'h0E8, 10'h1B0};
  localparam logic [7:0] QC_T [12] = '{8'h01, 8'h40, 8'h41, 8'h80,
    8'h81, 8'h0A, 8'h49, 8'h88, 8'h88, 8'h13, 8'h91, 8'h1C};
  localparam logic [4:0] DR_T [12] = '{5'h01, 5'h01, 5'h01, 5'h01,
    5'h01, 5'h01, 5'h01, 5'h01, 5'h02, 5'h04, 5'h10, 5'h08};
  localparam logic [9:0] LINK_T [12] = '{10'h00D, 10'h01C, 10'h01C,
    10'h035, 10'h035, 10'h007, 10'h00D, 10'h01C, 10'h01E, 10'h004,
    10'h00D, 10'h002};
  logic        ref_clk      = 1'b0;
  logic        reset        = 1'b1;
  logic [11:0] reg_addr     = 12'h000;
  logic        reg_wr_en    = 1'b0;
  logic [7:0]  reg_wr_data  = 8'h00;
  logic [2:0]  app_mode     = 3'h0;
  logic [4:0]  dec_ratio    = 5'h01;
  logic        sample_valid = 1'b0;
  logic [13:0] sample_a     = 14'h0ABC;
  logic [13:0] sample_b     = 14'h1DEF;
  logic        stall        = 1'b0;
  logic [7:0]  reg_rd_data;
  logic        sample_ready;
  logic        out_valid;
  logic        out_ready;
  logic [13:0] out_a;
  logic [13:0] out_b;
  logic [3:0]  ddc_i_pattern_en;
  logic [3:0]  ddc_q_pattern_en;
  logic [9:0]  core_latency;
  logic [9:0]  proc_latency;
  logic [9:0]  link_latency;
  logic [9:0]  total_latency;
  int          n_fail       = 0;
  int          samples_checked = 0;
  int          cycles       = 0;

  test_pattern_top #(.FIFO_WORDS(8)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .app_mode(app_mode), .dec_ratio(dec_ratio),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_a(sample_a), .sample_b(sample_b), .out_valid(out_valid),
    .out_ready(out_ready), .out_a(out_a), .out_b(out_b),
    .ddc_i_pattern_en(ddc_i_pattern_en),
    .ddc_q_pattern_en(ddc_q_pattern_en), .core_latency(core_latency),
    .proc_latency(proc_latency), .link_latency(link_latency),
    .total_latency(total_latency));
  stream_sink sink_u (.ref_clk(ref_clk), .out_valid(out_valid),
    .out_ready(out_ready), .out_a(out_a), .out_b(out_b), .stall(stall));

  always #5 ref_clk = ~ref_clk;

  // ----
  // shared tasks
  // ----
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [13:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr_en = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr = a;
    repeat (2) @(posedge ref_clk);
    #1 d = reg_rd_data;
  endtask

  task automatic push(input int n);
    int k;
    k = 0;
    while (k < n) begin
      sample_valid = 1'b1;
      if (sample_ready === 1'b1)
        k++;
      @(posedge ref_clk);
      #1;
    end
    sample_valid = 1'b0;
  endtask

  function automatic logic [13:0] pat(input logic [7:0] c, input int k);
    logic [15:0] w;
    w = 16'h1234 + 16'h1111 * 16'(k % 4);
    case (c[3:0])
      4'h0: return sample_a;
      4'h1: return 14'h0000;
      4'h2: return 14'h1FFF;
      4'h3: return 14'h2000;
      4'h4: return k[0] ? 14'h2AAA : 14'h1555;
      4'h5: return k == 0 ? 14'h3FD7 : k == 1 ? 14'h0002 : 14'h26E0;
      4'h6: return k == 0 ? 14'h125B : k == 1 ? 14'h3C9A : 14'h2660;
      4'h7: return k[0] ? 14'h3FFF : 14'h0000;
      4'h8: return (c[7] && k > 3) ? 14'h0000 : w[15:2];
      default: return k[13:0];
    endcase
  endfunction

  // ----
  // scenarios
  // ----
  task automatic run_mode(input logic [7:0] pre, c, input int n, hold);
    wr(ADDR_TEST_CTRL, pre);
    wr(ADDR_TEST_CTRL, c);
    sink_u.got_a.delete();
    sink_u.got_b.delete();
    stall = (hold > 0);
    fork
      push(n);
      begin
        repeat (hold) @(posedge ref_clk);
        #1 if (hold > 0) chk("sample_ready", 14'h0, {13'h0, sample_ready});
        stall = 1'b0;
      end
    join
    repeat (12) @(posedge ref_clk);
    #1 chk("count", 14'(n), 14'(sink_u.got_a.size()));
    for (int k = 0; k < n && k < sink_u.got_a.size(); k++) begin
      chk("out_a", pat(c, k), sink_u.got_a[k]);
      chk("out_b", c == 8'h00 ? sample_b : pat(c, k), sink_u.got_b[k]);
    end
    chk("out_valid", 14'h0, {13'h0, out_valid});
    $display("test mode %h done", c);
  endtask

  task automatic reg_test();
    logic [7:0] d;
    rd(ADDR_TEST_CTRL, d);
    chk("reset value", 14'h0000, {6'h00, d});
    wr(ADDR_TEST_CTRL, 8'h0F);
    rd(ADDR_TEST_CTRL, d);
    chk("test ctrl", 14'h000F, {6'h00, d});
    wr(12'h100, 8'hFF);
    rd(12'h100, d);
    chk("unmapped", 14'h0000, {6'h00, d});
    wr(ADDR_DDC0_CTRL, 8'h05);
    wr(ADDR_FOURTH_DOWNCONVERTER_CTRL, 8'h05);
    @(posedge ref_clk);
    #1 chk("i enables", 14'h0009, {10'h000, ddc_i_pattern_en});
    chk("q enables", 14'h0001, {10'h000, ddc_q_pattern_en});
    $display("register test done");
  endtask

  task automatic lat_test();
    for (int m = 0; m < 8; m++) begin
      app_mode = 3'(m);
      repeat (2) @(posedge ref_clk);
      #1 chk("proc", {4'h0, PROC_T[m]}, {4'h0, proc_latency});
    end
    for (int i = 0; i < 12; i++) begin
      dec_ratio = DR_T[i];
      wr(ADDR_QUICK_CFG, QC_T[i]);
      repeat (2) @(posedge ref_clk);
      #1 chk("link", {4'h0, LINK_T[i]}, {4'h0, link_latency});
      chk("total", {4'h0, PROC_T[7] + LINK_T[i]}, {4'h0, total_latency});
    end
    chk("core", 14'h001A, {4'h0, core_latency});
    $display("latency test done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    #1 reset = 1'b0;
    @(posedge ref_clk);
    #1;
    reg_test();
    lat_test();
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_USER_FIRST + 12'(2 * k), 8'(16'h1234 + 16'h1111 * k));
      wr(ADDR_USER_FIRST + 12'(2 * k + 1), 8'((16'h1234 + 16'h1111 * k) >> 8));
    end
    run_mode(8'h00, 8'h00, 3, 0);
    run_mode(8'h00, 8'h01, 2, 0);
    run_mode(8'h00, 8'h02, 2, 0);
    run_mode(8'h00, 8'h03, 2, 0);
    run_mode(8'h00, 8'h04, 4, 0);
    run_mode(8'h10, 8'h05, 3, 0);
    run_mode(8'h15, 8'h05, 2, 0);
    run_mode(8'h25, 8'h05, 2, 0);
    run_mode(8'h20, 8'h06, 3, 0);
    run_mode(8'h26, 8'h06, 2, 0);
    run_mode(8'h00, 8'h07, 5, 0);
    run_mode(8'h00, 8'h08, 6, 0);
    run_mode(8'h00, 8'h88, 6, 0);
    run_mode(8'h00, 8'h0F, 12, 16);
    conclude();
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end
endmodule
`default_nettype wire
